// ===== pmr_pkg.sv
package pmr_pkg;
    localparam logic [6:0] DEV_ADDR_DEFAULT  = 7'h40;
    localparam int         SAMPLE_W          = 12;
    // Status byte bit positions
    localparam int         ST_CONVERTER_OVERCURRENT_SEEN         = 0;
    localparam int         ST_ADC_ALERT      = 1;
    localparam int         ST_OC_LIVE        = 2;
    localparam int         ST_TRIP_LATCHED   = 3;
    localparam int         ST_OFF_STATUS     = 4;
    localparam int         ST_OFF_ALERT      = 5;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam int         CONVERTER_OVERCURRENT_SEEN_RUN        = 3;

    typedef enum logic [1:0] {
        MODE_BOTH,
        MODE_VOLT,
        MODE_CURR
    } pmr_mode_t;

    typedef struct packed {
        logic [11:0] volt;
        logic [11:0] curr;
    } pmr_sample_t;
endpackage

// ===== pmr_sync.sv
`timescale 1ns/10ps
module pmr_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    // First stage read only by the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage1 <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// ===== power_monitor_readback_status.sv
`timescale 1ns/10ps
module power_monitor_readback_status #(
    parameter logic [6:0] DEV_ADDR = pmr_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 sclIn,
    input  wire logic                 sdaIn,
    output logic                      sdaOut,
    output logic                      sdaOe,
    output logic                      alertOut,
    output logic                      alertOe,
    output logic [7:0]                alert_status_flags,
    input  wire pmr_pkg::pmr_mode_t   readMode,
    input  wire logic                 statusSelect,
    input  wire logic                 voltage_continuous,
    input  wire logic                 current_continuous,
    input  wire logic                 singleShotBusy,
    input  wire logic                 convDone,
    input  wire pmr_pkg::pmr_sample_t convData,
    input  wire logic                 convOverThreshold,
    input  wire logic                 alertEnAdc,
    input  wire logic                 alertEnTrip,
    input  wire logic                 alertEnOff,
    input  wire logic                 force_release_ctl,
    input  wire logic                 clearPulse,
    input  wire logic                 overcurrent_live
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pinSync;
    logic       scl;
    logic       sda;
    logic       ocLive;
    logic       sclPrev;
    logic       sdaPrev;

    // Comparator idles low, bus lines idle high: no false event after reset
    pmr_sync #(.WIDTH(3), .RST_VAL(3'b110)) uSync (
        .clock (clock),
        .rst   (rst),
        .din   ({sclIn, sdaIn, overcurrent_live}),
        .dout  (pinSync)
    );
    assign scl    = pinSync[2];
    assign sda    = pinSync[1];
    assign ocLive = pinSync[0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end

    wire sclRise  = scl & ~sclPrev;
    wire sclFall  = ~scl & sclPrev;
    wire startCnd = scl & sclPrev & sdaPrev & ~sda;
    wire stopCnd  = scl & sclPrev & ~sdaPrev & sda;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion holding and status
    pmr_pkg::pmr_sample_t sample;
    logic                 haveData;
    logic [1:0]           ocRun;
    logic                 adcOc;
    logic                 adcAlert;
    logic                 tripLatched;
    logic                 offStatus;
    logic                 offAlert;
    logic                 forcePrev;

    wire forceWrite = force_release_ctl & ~forcePrev;
    wire adcTrip    = adcOc & alertEnAdc;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample    <= '0;
            haveData  <= 1'b0;
            ocRun     <= 2'h0;
            adcOc     <= 1'b0;
            forcePrev <= 1'b0;
        end else begin
            forcePrev <= force_release_ctl;
            if (convDone) begin
                sample   <= convData;
                haveData <= 1'b1;
                if (!convOverThreshold) begin
                    ocRun <= 2'h0;
                    adcOc <= 1'b0;
                end else if (32'(ocRun) + 1 >= pmr_pkg::CONVERTER_OVERCURRENT_SEEN_RUN) begin
                    // Run count parks here while the flag stands
                    adcOc <= 1'b1;
                end else begin
                    ocRun <= ocRun + 2'h1;
                end
            end
        end
    end

    // Set wins over clear so a persisting source relatches at once
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            adcAlert    <= 1'b0;
            tripLatched <= 1'b0;
            offStatus   <= 1'b0;
            offAlert    <= 1'b0;
        end else begin
            adcAlert    <= adcTrip | (adcAlert & ~clearPulse);
            tripLatched <= (ocLive & alertEnTrip) | (tripLatched & ~clearPulse);
            offStatus   <= forceWrite | offStatus;
            offAlert    <= (forceWrite & alertEnOff) | (offAlert & ~clearPulse);
        end
    end

    // Assembled by position so the byte layout lives in one place
    logic [7:0] statusByte;
    always_comb begin
        statusByte                           = 8'h00;
        statusByte[pmr_pkg::ST_CONVERTER_OVERCURRENT_SEEN]       = adcOc;
        statusByte[pmr_pkg::ST_ADC_ALERT]    = adcAlert;
        statusByte[pmr_pkg::ST_OC_LIVE]      = ocLive;
        statusByte[pmr_pkg::ST_TRIP_LATCHED] = tripLatched;
        statusByte[pmr_pkg::ST_OFF_STATUS]   = offStatus;
        statusByte[pmr_pkg::ST_OFF_ALERT]    = offAlert;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            alert_status_flags <= pmr_pkg::STATUS_RESET;
            alertOe            <= 1'b0;
            alertOut           <= 1'b0;
        end else begin
            alert_status_flags <= statusByte;
            // Pin level stays low; only the enable signals the alert
            alertOut           <= 1'b0;
            // Force-release only wins while its alert path is enabled
            alertOe <= (tripLatched | adcAlert) & ~(force_release_ctl & alertEnOff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read byte formatting
    // Zeros until the first conversion lands
    wire [11:0] vData = haveData ? sample.volt : 12'h000;
    wire [11:0] iData = haveData ? sample.curr : 12'h000;
    wire [1:0]  lastIdx = statusSelect ? 2'd0 : (readMode == pmr_pkg::MODE_BOTH) ? 2'd2 : 2'd1;

    logic [1:0] byteIdx;
    logic [7:0] txByte;
    always_comb begin
        txByte = 8'h00;
        if (statusSelect) begin
            txByte = statusByte;
        end else begin
            unique case (readMode)
                pmr_pkg::MODE_BOTH: begin
                    txByte = (byteIdx == 2'd0) ? vData[11:4] :
                             (byteIdx == 2'd1) ? iData[11:4] : {vData[3:0], iData[3:0]};
                end
                pmr_pkg::MODE_VOLT: begin
                    txByte = (byteIdx == 2'd0) ? vData[11:4] : {vData[3:0], 4'h0};
                end
                pmr_pkg::MODE_CURR: begin
                    txByte = (byteIdx == 2'd0) ? iData[11:4] : {iData[3:0], 4'h0};
                end
                // Unused mode code returns zeros
                default: txByte = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave state machine
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_SEND,
        ST_MACK,
        ST_WAIT
    } pmr_state_t;

    pmr_state_t state;
    logic [2:0] bitCnt;
    logic [7:0] shiftReg;
    logic       noCont;

    // Single-shot busy refuses the address; continuous modes always answer
    wire blockRead = singleShotBusy & ~(voltage_continuous | current_continuous);
    wire addrHit   = (shiftReg[6:0] == DEV_ADDR) & sda & ~blockRead;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            bitCnt   <= 3'h0;
            shiftReg <= 8'h00;
            byteIdx  <= 2'd0;
            sdaOe    <= 1'b0;
            noCont   <= 1'b0;
        end else if (startCnd) begin
            // Every read starts again at its first byte
            state   <= ST_ADDR;
            bitCnt  <= 3'h0;
            byteIdx <= 2'd0;
            sdaOe   <= 1'b0;
        end else if (stopCnd) begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: sdaOe <= 1'b0;
                ST_ADDR: begin
                    // Eighth rise carries the read bit
                    if (sclRise) begin
                        shiftReg <= {shiftReg[6:0], sda};
                        bitCnt   <= bitCnt + 3'h1;
                        if (bitCnt == 3'h7) begin
                            state <= addrHit ? ST_ACK : ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    // First fall drives the acknowledge, the second loads the byte
                    if (sclFall && !sdaOe) begin
                        sdaOe <= 1'b1;
                    end else if (sclFall) begin
                        state    <= ST_SEND;
                        bitCnt   <= 3'h0;
                        shiftReg <= txByte;
                        sdaOe    <= ~txByte[7];
                    end
                end
                ST_SEND: begin
                    // Eighth fall ends the byte and frees the line for the master
                    if (sclFall) begin
                        if (bitCnt == 3'h7) begin
                            state <= ST_MACK;
                            sdaOe <= 1'b0;
                        end else begin
                            shiftReg <= {shiftReg[6:0], 1'b0};
                            sdaOe    <= ~shiftReg[6];
                            bitCnt   <= bitCnt + 3'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // Index moves on the rise so the fall already loads the next byte
                    if (sclRise) begin
                        noCont  <= sda | (byteIdx == lastIdx);
                        byteIdx <= byteIdx + 2'd1;
                    end else if (sclFall) begin
                        if (noCont) begin
                            state <= ST_WAIT;
                        end else begin
                            state    <= ST_SEND;
                            bitCnt   <= 3'h0;
                            shiftReg <= txByte;
                            sdaOe    <= ~txByte[7];
                        end
                    end
                end
                ST_WAIT: sdaOe <= 1'b0;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Open drain: data level is always low, only the enable moves
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sdaOut <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
        end
    end
endmodule

// ===== pmr_chk.sv
`timescale 1ns/10ps
module pmr_chk (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sdaOe,
    input wire logic       alertOut,
    input wire logic       alertOe,
    input wire logic [7:0] alert_status_flags,
    input wire logic       convDone,
    input wire logic       convOverThreshold,
    input wire logic       alertEnAdc,
    input wire logic       alertEnTrip,
    input wire logic       alertEnOff,
    input wire logic       force_release_ctl,
    input wire logic       clearPulse,
    input wire logic       overcurrent_live
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Own run count of over-threshold conversions, saturating at 3
    logic [1:0] runCnt;
    wire  [7:0] f = alert_status_flags;
    wire  [1:0] next_runCnt = !convOverThreshold ? 2'h0 : (runCnt == 2'h3) ? 2'h3 : runCnt + 2'h1;
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            runCnt <= 2'h0;
        else if (convDone)
            runCnt <= next_runCnt;
    end
    ////////////////////////////////////////////////////////////////
    AST_BITS_ZERO: assert property (f[7:6] == 2'h0)
        else $error("status bits 7:6 set");
    AST_LIVE: assert property ($stable(overcurrent_live)[*6] |-> f[2] == overcurrent_live)
        else $error("live flag wrong");
    AST_TRIP: assert property (f[2] && alertEnTrip |-> ##[0:2] f[3])
        else $error("trip not latched");
    AST_PIN: assert property (f[3] && !alertEnOff |-> ##[0:2] alertOe && !alertOut)
        else $error("alert pin not low");
    AST_IDLE: assert property ((!f[1] && !f[3])[*3] |-> !alertOe)
        else $error("alert pin held low");
    AST_RUN: assert property ($stable(runCnt)[*3] |-> f[0] == (runCnt == 2'h3))
        else $error("converter flag wrong");
    AST_ADC_ALERT: assert property (f[0] && alertEnAdc |-> ##[0:2] f[1])
        else $error("converter alert not latched");
    AST_OFF: assert property ($rose(force_release_ctl) |-> ##[1:4] f[4])
        else $error("off status not set");
    AST_OFF_ALERT: assert property ($rose(force_release_ctl) && alertEnOff |-> ##[1:4] f[5])
        else $error("off alert not set");
    AST_CLEAR: assert property (clearPulse && !force_release_ctl && !overcurrent_live
        && !$past(overcurrent_live, 4) |-> ##[1:3] !f[5] && !f[3])
        else $error("clear failed");
    AST_HOLD: assert property ($fell(f[3]) |-> $past(clearPulse) || $past(clearPulse, 2))
        else $error("trip dropped without clear");
    cover property (f[5]);
    cover property (f[1]);
    cover property (sdaOe ##1 !sdaOe);
endmodule
bind power_monitor_readback_status pmr_chk chk_u (.clock, .rst, .sdaOe, .alertOut, .alertOe, .alert_status_flags,
    .convDone, .convOverThreshold, .alertEnAdc, .alertEnTrip, .alertEnOff, .force_release_ctl, .clearPulse,
    .overcurrent_live);

// ===== pmr_i2c_master.sv
`timescale 1ns/10ps
module pmr_i2c_master #(
    parameter logic [6:0] ADDR = 7'h40
) (
    input  wire logic clock,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaDrv
);
    // Bus idles released; SCL stands still between frames
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic q(input int n);
        repeat (2 * n) @(posedge clock);
    endtask
    // Sampled late in SCL high, after the slave's slow update
    task automatic bitx(input logic b, output logic r);
        sdaDrv <= b;
        q(1);
        scl <= 1'b1;
        q(2);
        r = sdaLine;
        scl <= 1'b0;
        q(1);
    endtask
    task automatic rd(input int n, output logic ok, output logic [23:0] d);
        logic       r;
        logic [7:0] a;
        a = {ADDR, 1'b1};
        d = 24'h000000;
        sdaDrv <= 1'b0;
        q(1);
        scl <= 1'b0;
        q(1);
        for (int i = 7; i >= 0; i--) bitx(a[i], r);
        bitx(1'b1, r);
        ok = !r;
        for (int k = 0; ok && k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                bitx(1'b1, r);
                d = {d[22:0], r};
            end
            bitx(k == n - 1, r);
        end
        sdaDrv <= 1'b0;
        q(1);
        scl <= 1'b1;
        q(1);
        sdaDrv <= 1'b1;
        q(2);
    endtask
endmodule

// ===== test_power_monitor_readback_status.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; $display("mismatch %0t got %h", $time, a); end end
module test_power_monitor_readback_status;
    typedef struct packed {
        pmr_pkg::pmr_mode_t   mode;
        pmr_pkg::pmr_sample_t smp;
        logic [1:0]           n;
        logic [23:0]          exp;
    } pmr_row_t;
    logic clock, rst, scl, sdaDrv, sdaOut, sdaOe, alertOut, alertOe, ok, statusSelect, singleShotBusy, convDone;
    logic convOverThreshold, alertEnAdc, alertEnTrip, alertEnOff, force_release_ctl, clearPulse, overcurrent_live;
    logic voltage_continuous, current_continuous;
    logic [7:0] flags;
    logic [23:0] d;
    pmr_pkg::pmr_mode_t readMode;
    pmr_pkg::pmr_sample_t convData;
    int errors, checks, cyc;
    wire sdaLine = sdaDrv & (!sdaOe | sdaOut);
    wire alertLine = !alertOe | alertOut;
    pmr_row_t rows [4] = '{'{pmr_pkg::MODE_BOTH, 24'habc123, 2'h3, 24'hab12c3},
        '{pmr_pkg::MODE_VOLT, 24'h5a7fff, 2'h2, 24'h005a70}, '{pmr_pkg::MODE_CURR, 24'hfff9e1, 2'h2, 24'h009e10},
        '{pmr_pkg::MODE_VOLT, 24'h5a7fff, 2'h3, 24'h5a70ff}};
    power_monitor_readback_status dut_u (.clock, .rst, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe,
        .alertOut, .alertOe, .alert_status_flags(flags), .readMode, .statusSelect, .voltage_continuous,
        .current_continuous, .singleShotBusy, .convDone, .convData, .convOverThreshold, .alertEnAdc,
        .alertEnTrip, .alertEnOff, .force_release_ctl, .clearPulse, .overcurrent_live);
    pmr_i2c_master #(.ADDR(pmr_pkg::DEV_ADDR_DEFAULT)) mst_u (.clock, .sdaLine, .scl, .sdaDrv);
    ////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic conv(input pmr_pkg::pmr_sample_t s, input logic o);
        @(posedge clock);
        convData <= s;
        convOverThreshold <= o;
        convDone <= 1'b1;
        @(posedge clock);
        convDone <= 1'b0;
    endtask
    task automatic clr;
        clearPulse <= 1'b1;
        @(posedge clock);
        clearPulse <= 1'b0;
    endtask
    // Flags settle through synchronisers; bounded wait
    task automatic wf(input logic [7:0] e);
        for (int i = 0; i < 12 && flags !== e; i++) @(posedge clock);
        `CHK(flags, e)
    endtask
    task automatic rdchk(input int n, input logic k, input logic [23:0] e);
        mst_u.rd(n, ok, d);
        `CHK(ok, k)
        `CHK(d, e)
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        {statusSelect, singleShotBusy, convDone, convOverThreshold, alertEnAdc, alertEnTrip} = 6'h00;
        {alertEnOff, force_release_ctl, clearPulse, overcurrent_live} = 4'h0;
        {voltage_continuous, current_continuous} = 2'h3;
        readMode = pmr_pkg::MODE_BOTH;
        convData = 24'h000000;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        `CHK({flags, sdaOe, alertOe}, 10'h000)
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            readMode <= rows[i].mode;
            conv(rows[i].smp, 1'b0);
            rdchk(rows[i].n, 1'b1, rows[i].exp);
        end
        $display("readback rows done");
        {voltage_continuous, current_continuous, singleShotBusy} <= 3'h1;
        rdchk(2, 1'b0, 24'h000000);
        singleShotBusy <= 1'b0;
        rdchk(2, 1'b1, 24'h005a70);
        $display("single shot done");
        alertEnTrip <= 1'b1;
        overcurrent_live <= 1'b1;
        wf(8'h0c);
        `CHK(alertLine, 1'b0)
        overcurrent_live <= 1'b0;
        wf(8'h08);
        `CHK(alertLine, 1'b0)
        clr();
        wf(8'h00);
        `CHK(alertLine, 1'b1)
        alertEnAdc <= 1'b1;
        repeat (3) conv(24'h000fff, 1'b1);
        wf(8'h03);
        conv(24'h000000, 1'b0);
        wf(8'h02);
        clr();
        wf(8'h00);
        $display("alert flags done");
        alertEnOff <= 1'b1;
        force_release_ctl <= 1'b1;
        statusSelect <= 1'b1;
        wf(8'h30);
        rdchk(1, 1'b1, 24'h000030);
        force_release_ctl <= 1'b0;
        clr();
        wf(8'h10);
        rdchk(1, 1'b1, 24'h000010);
        $display("status read done");
        conv(24'habc123, 1'b0);
        rst <= 1'b1;
        @(posedge clock);
        {rst, statusSelect, voltage_continuous, singleShotBusy} <= 4'h3;
        readMode <= pmr_pkg::MODE_BOTH;
        repeat (3) @(posedge clock);
        `CHK(flags, 8'h00)
        rdchk(3, 1'b1, 24'h000000);
        $display("reset read done");
        stop_test();
    end
endmodule
